// ===== shared/sgc_pkg.sv
// Constants of the global switch control bank at 0x05..0x09 and 0x20 and its helpers.
// Assumes one 100 MHz core clock and an 8-bit register port.
// Function
// - Feature bit 7 turns on 802.1Q VLAN forwarding; resets to 0.
// - Feature bit 6 sends every IGMP packet to the host MII port.
// - Bits 5 and 4 enable MLD snooping and its option; both reset 0.
// - Bit 3 clear: strict priority, highest non-empty queue always sent first.
// - Bit 3 set with all queues busy: bandwidth shared 8:4:2:1.
// - Any queue empty: highest non-empty queue gets one extra weight unit.
// - Sniff bit set: mirror only when both source and destination match.
// - Sniff bit clear: mirror when source or destination matches.
// - Host bit 6 half duplex; reset value from duplex strap.
// - Host bit 5 flow control; reset value from flow control strap.
// - Host bit 4 selects 10 Mb; reset value from speed strap.
// - Host bit 3 replaces NULL VID of tagged frames with port VID.
// - Storm limit is 11 bits: high three in 0x06, low eight in 0x07.
// - Limit counts 64-byte blocks per port over 67 ms or 500 ms.
// - Multicast exclusion on: only broadcast regulated; else group DAs too.
package sgc_pkg;
  localparam logic [7:0] ADDR_FEATURE   = 8'h05;
  localparam logic [7:0] ADDR_HOST      = 8'h06;
  localparam logic [7:0] ADDR_RATE_LO   = 8'h07;
  localparam logic [7:0] ADDR_TEST_A    = 8'h08;
  localparam logic [7:0] ADDR_TEST_B    = 8'h09;
  localparam logic [7:0] ADDR_STORM_OPT = 8'h20;

  localparam int BIT_VLAN      = 7;
  localparam int BIT_IGMP      = 6;
  localparam int BIT_MLD       = 5;
  localparam int BIT_MLD_OPT   = 4;
  localparam int BIT_WFQ       = 3;
  localparam int BIT_SNIFF_AND = 0;
  localparam int BIT_REPEATER  = 7;
  localparam int BIT_HALF      = 6;
  localparam int BIT_FLOWCTL   = 5;
  localparam int BIT_10M       = 4;
  localparam int BIT_NULL_VID  = 3;
  localparam int BIT_RATE_HI   = 0;
  localparam int BIT_MC_EXCL   = 0;

  localparam logic [7:0] RST_FEATURE  = 8'h00;
  localparam logic [7:0] RST_HOST     = 8'h00;
  localparam logic [7:0] RST_RATE_LO  = 8'h63;
  localparam logic [7:0] RST_TEST_A   = 8'h00;
  localparam logic [7:0] RST_TEST_B   = 8'h24;
  localparam logic       RST_MC_EXCL  = 1'b1;
  localparam logic [7:0] FEATURE_MASK = 8'hF9;

  localparam logic [3:0] WEIGHT_TOP    = 4'h8;
  localparam logic [3:0] WEIGHT_SECOND = 4'h4;
  localparam logic [3:0] WEIGHT_THIRD  = 4'h2;
  localparam logic [3:0] WEIGHT_LOWEST = 4'h1;

  localparam int CLK_MHZ        = 100;
  localparam int PERIOD_100M_MS = 67;
  localparam int PERIOD_10M_MS  = 500;
  localparam int PERIOD_100M_CYC = PERIOD_100M_MS * 1000 * CLK_MHZ;
  localparam int PERIOD_10M_CYC  = PERIOD_10M_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    SGC_CAP_WAIT0 = 2'b00,
    SGC_CAP_WAIT1 = 2'b01,
    SGC_CAP_WAIT2 = 2'b11,
    SGC_CAP_DONE  = 2'b10
  } sgc_cap_e;
endpackage

// ===== src/sgc_global_ctrl.sv
// Global control bank: feature enables, host MII setup, storm limiter,
// egress queue scheduler, sniff match and NULL VID replacement.
// Assumes a register master that holds no strobe during reset and
// packet-side inputs that are synchronous to mclk_in.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module sgc_global_ctrl #(
  parameter int NPORTS          = 3,
  parameter int BLK_W           = 5,
  parameter int PERIOD_100M_CYC = sgc_pkg::PERIOD_100M_CYC,
  parameter int PERIOD_10M_CYC  = sgc_pkg::PERIOD_10M_CYC
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_in,
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [7:0]                reg_rdata_out,
  input  wire logic                      host_rx_data_strap_duplex_in,
  input  wire logic                      host_rx_data_strap_flowctl_in,
  input  wire logic                      host_rx_data_strap_speed_in,
  output logic                           vlan_enable_out,
  output logic                           igmp_snoop_out,
  output logic                           mld_snoop_out,
  output logic                           mld_option_out,
  output logic                           repeater_out,
  output logic                           host_half_duplex_out,
  output logic                           host_flowctl_out,
  output logic                           host_10m_out,
  input  wire logic [3:0]                queue_busy_in,
  input  wire logic                      sched_req_in,
  output logic      [3:0]                grant_out,
  output logic                           grant_valid_out,
  input  wire logic                      sniff_check_in,
  input  wire logic                      sniff_src_match_in,
  input  wire logic                      sniff_dst_match_in,
  output logic                           mirror_out,
  input  wire logic                      igmp_pkt_in,
  output logic                           to_host_out,
  input  wire logic                      vid_check_in,
  input  wire logic                      vid_tagged_in,
  input  wire logic [11:0]               vid_in,
  input  wire logic [11:0]               port_vid_in,
  output logic      [11:0]               vid_out,
  input  wire logic                      link_10m_in,
  input  wire logic                      pkt_valid_in,
  input  wire logic [1:0]                pkt_port_in,
  input  wire logic                      pkt_da_bcast_in,
  input  wire logic                      pkt_da_group_in,
  input  wire logic [BLK_W-1:0]          pkt_blocks_in,
  output logic                           drop_out,
  output logic                           period_start_out
);
  import sgc_pkg::*;

  localparam int CNT_W    = 12;
  localparam int PERIOD_W = 26;

  initial begin
    if (NPORTS < 1 || NPORTS > 4 || BLK_W < 1 || BLK_W > 8 ||
        PERIOD_100M_CYC < 2 || PERIOD_10M_CYC < 2 ||
        PERIOD_10M_CYC >= (1 << PERIOD_W) || PERIOD_100M_CYC >= (1 << PERIOD_W)) begin
      $error("sgc_global_ctrl: unsupported parameter values");
    end
  end

  typedef struct packed {
    sgc_cap_e                       cap;
    logic [2:0]                     sync1;
    logic [2:0]                     sync2;
    logic [7:0]                     feat;
    logic [7:0]                     host;
    logic [7:0]                     rate_lo;
    logic [7:0]                     test_a;
    logic [7:0]                     test_b;
    logic                           mc_excl;
    logic [7:0]                     rdata;
    logic [3:0][3:0]                credit;
    logic [3:0]                     grant;
    logic                           grant_valid;
    logic                           mirror;
    logic                           to_host;
    logic [11:0]                    vid;
    logic                           drop;
    logic                           period_start;
    logic [PERIOD_W-1:0]            period_cnt;
    logic [NPORTS-1:0][CNT_W-1:0]   blk_cnt;
  } sgc_state_s;

  sgc_state_s st;
  sgc_state_s next_st;

  logic [3:0][3:0] weight;
  logic [3:0][3:0] eff;
  logic [3:0]      top_busy;
  logic [3:0]      pick;
  logic            has_credit;
  logic [10:0]     limit;
  logic            regulated;
  logic [CNT_W-1:0] cur_cnt;
  logic [CNT_W:0]   sum_cnt;

  assign weight = {WEIGHT_TOP, WEIGHT_SECOND, WEIGHT_THIRD, WEIGHT_LOWEST};
  assign limit  = {st.host[BIT_RATE_HI +: 3], st.rate_lo};

  // ---------------------------------------------------------------
  // Scheduler selection
  // ---------------------------------------------------------------
  always_comb begin
    top_busy   = 4'h0;
    has_credit = 1'b0;
    pick       = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (queue_busy_in[i] && top_busy == 4'h0) begin
        top_busy[i] = 1'b1;
      end
      if (queue_busy_in[i] && st.credit[i] != 4'h0) begin
        has_credit = 1'b1;
      end
    end
    eff = st.credit;
    if (!has_credit) begin
      // A new round starts only once every busy queue spent its share
      for (int i = 0; i < 4; i++) begin
        eff[i] = weight[i];
        if (top_busy[i] && queue_busy_in != 4'hF) begin
          eff[i] = weight[i] + 4'h1;
        end
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (queue_busy_in[i] && pick == 4'h0) begin
        if (!st.feat[BIT_WFQ] || eff[i] != 4'h0) begin
          pick[i] = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Storm limiter helpers
  // ---------------------------------------------------------------
  always_comb begin
    regulated = pkt_da_bcast_in || (!st.mc_excl && pkt_da_group_in);
    cur_cnt   = '0;
    for (int p = 0; p < NPORTS; p++) begin
      if (pkt_port_in == 2'(p)) begin
        cur_cnt = st.blk_cnt[p];
      end
    end
    sum_cnt = {1'b0, cur_cnt} + (CNT_W + 1)'(pkt_blocks_in);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st              = st;
    next_st.sync1        = {host_rx_data_strap_duplex_in, host_rx_data_strap_flowctl_in,
                            host_rx_data_strap_speed_in};
    next_st.sync2        = st.sync1;
    next_st.rdata        = 8'h00;
    next_st.grant_valid  = 1'b0;
    next_st.drop         = 1'b0;
    next_st.period_start = 1'b0;

    // Straps settle through both synchroniser stages before being caught once;
    // the extra wait keeps the reset zero of the second stage from being caught
    unique case (st.cap)
      SGC_CAP_WAIT0: next_st.cap = SGC_CAP_WAIT1;
      SGC_CAP_WAIT1: next_st.cap = SGC_CAP_WAIT2;
      SGC_CAP_WAIT2: begin
        next_st.cap             = SGC_CAP_DONE;
        next_st.host[BIT_HALF]    = st.sync2[2];
        next_st.host[BIT_FLOWCTL] = st.sync2[1];
        next_st.host[BIT_10M]     = st.sync2[0];
      end
      SGC_CAP_DONE: next_st.cap = SGC_CAP_DONE;
    endcase

    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_FEATURE:   next_st.feat    = reg_wdata_in;
        ADDR_HOST:      next_st.host    = reg_wdata_in;
        ADDR_RATE_LO:   next_st.rate_lo = reg_wdata_in;
        ADDR_TEST_A:    next_st.test_a  = reg_wdata_in;
        ADDR_TEST_B:    next_st.test_b  = reg_wdata_in;
        ADDR_STORM_OPT: next_st.mc_excl = reg_wdata_in[BIT_MC_EXCL];
        default:        next_st.mc_excl = st.mc_excl;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_FEATURE:   next_st.rdata = st.feat;
        ADDR_HOST:      next_st.rdata = st.host;
        ADDR_RATE_LO:   next_st.rdata = st.rate_lo;
        ADDR_TEST_A:    next_st.rdata = st.test_a;
        ADDR_TEST_B:    next_st.rdata = st.test_b;
        ADDR_STORM_OPT: next_st.rdata = {7'h00, st.mc_excl};
        default:        next_st.rdata = 8'h00;
      endcase
    end

    if (sched_req_in && queue_busy_in != 4'h0) begin
      next_st.grant       = pick;
      next_st.grant_valid = 1'b1;
      if (st.feat[BIT_WFQ]) begin
        next_st.credit = eff;
        for (int i = 0; i < 4; i++) begin
          if (pick[i]) begin
            next_st.credit[i] = eff[i] - 4'h1;
          end
        end
      end
    end

    // Mirroring: AND mode for both directions, OR mode also covers rx-only sniff
    if (st.feat[BIT_SNIFF_AND]) begin
      next_st.mirror = sniff_check_in && sniff_src_match_in && sniff_dst_match_in;
    end else begin
      next_st.mirror = sniff_check_in && (sniff_src_match_in || sniff_dst_match_in);
    end
    next_st.to_host = igmp_pkt_in && st.feat[BIT_IGMP];

    if (vid_check_in) begin
      next_st.vid = vid_in;
      if (st.host[BIT_NULL_VID] && vid_tagged_in && vid_in == 12'h000) begin
        next_st.vid = port_vid_in;
      end
    end

    if (st.period_cnt == '0) begin
      next_st.period_start = 1'b1;
      next_st.period_cnt   = link_10m_in ? PERIOD_W'(PERIOD_10M_CYC - 1)
                                         : PERIOD_W'(PERIOD_100M_CYC - 1);
      next_st.blk_cnt      = '0;
    end else begin
      next_st.period_cnt = st.period_cnt - PERIOD_W'(1);
      if (pkt_valid_in && regulated && int'(pkt_port_in) < NPORTS) begin
        if (cur_cnt >= CNT_W'(limit)) begin
          next_st.drop = 1'b1;
        end else begin
          for (int p = 0; p < NPORTS; p++) begin
            if (pkt_port_in == 2'(p)) begin
              // Saturates so a long burst cannot wrap below the limit
              next_st.blk_cnt[p] = sum_cnt[CNT_W] ? {CNT_W{1'b1}} : sum_cnt[CNT_W-1:0];
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st         <= '0;
      st.cap     <= SGC_CAP_WAIT0;
      st.feat    <= RST_FEATURE;
      st.host    <= RST_HOST;
      st.rate_lo <= RST_RATE_LO;
      st.test_a  <= RST_TEST_A;
      st.test_b  <= RST_TEST_B;
      st.mc_excl <= RST_MC_EXCL;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out        = st.rdata;
  assign vlan_enable_out      = st.feat[BIT_VLAN];
  assign igmp_snoop_out       = st.feat[BIT_IGMP];
  assign mld_snoop_out        = st.feat[BIT_MLD];
  assign mld_option_out       = st.feat[BIT_MLD_OPT];
  assign repeater_out         = st.host[BIT_REPEATER];
  assign host_half_duplex_out = st.host[BIT_HALF];
  assign host_flowctl_out     = st.host[BIT_FLOWCTL];
  assign host_10m_out         = st.host[BIT_10M];
  assign grant_out            = st.grant;
  assign grant_valid_out      = st.grant_valid;
  assign mirror_out           = st.mirror;
  assign to_host_out          = st.to_host;
  assign vid_out              = st.vid;
  assign drop_out             = st.drop;
  assign period_start_out     = st.period_start;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_vlan_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == ADDR_FEATURE |=> vlan_enable_out == $past(reg_wdata_in[7]))
    else $error("vlan enable not written");
  chk_igmp_forward: assert property (@(posedge mclk_in) disable iff (rst_in)
    to_host_out |-> $past(igmp_pkt_in) && $past(igmp_snoop_out))
    else $error("igmp forward without cause");
  chk_mld_bits: assert property (@(posedge mclk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == ADDR_FEATURE
    |=> reg_rdata_out[5:4] == {$past(mld_snoop_out), $past(mld_option_out)})
    else $error("mld bits mismatch");
  chk_strict_pick: assert property (@(posedge mclk_in) disable iff (rst_in)
    sched_req_in && !st.feat[BIT_WFQ] && queue_busy_in[3] |=> grant_out == 4'h8)
    else $error("strict priority violated");
  chk_wfq_round: assert property (@(posedge mclk_in) disable iff (rst_in)
    sched_req_in && st.feat[BIT_WFQ] && queue_busy_in == 4'hF && !has_credit
    |=> st.credit == {4'h7, 4'h4, 4'h2, 4'h1})
    else $error("weighted round reload wrong");
  chk_wfq_bonus: assert property (@(posedge mclk_in) disable iff (rst_in)
    sched_req_in && st.feat[BIT_WFQ] && queue_busy_in == 4'hB && !has_credit
    |=> st.credit[3] == 4'h8 && st.credit[2] == 4'h4)
    else $error("extra weight unit missing");
  chk_sniff_and: assert property (@(posedge mclk_in) disable iff (rst_in)
    sniff_check_in && st.feat[BIT_SNIFF_AND] && !sniff_dst_match_in |=> !mirror_out)
    else $error("and sniff mirrored a half match");
  chk_sniff_or: assert property (@(posedge mclk_in) disable iff (rst_in)
    sniff_check_in && !st.feat[BIT_SNIFF_AND] && sniff_src_match_in |=> mirror_out)
    else $error("or sniff missed a match");
  chk_strap_catch: assert property (@(posedge mclk_in) disable iff (rst_in)
    st.cap == SGC_CAP_WAIT2 ##1 !(($past(reg_wr_in) && $past(reg_addr_in) == ADDR_HOST))
    |-> host_half_duplex_out == $past(st.sync2[2]))
    else $error("duplex strap not caught");
  chk_null_vid: assert property (@(posedge mclk_in) disable iff (rst_in)
    vid_check_in && vid_tagged_in && vid_in == 12'h000 && st.host[BIT_NULL_VID]
    |=> vid_out == $past(port_vid_in))
    else $error("null vid not replaced");
  chk_storm_drop: assert property (@(posedge mclk_in) disable iff (rst_in)
    drop_out |-> $past(pkt_valid_in) && $past(cur_cnt) >= CNT_W'($past(limit)))
    else $error("drop below limit");
  chk_period_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
    period_start_out |-> st.blk_cnt == '0)
    else $error("counts not cleared at period start");
endmodule

// ===== testbench/sgc_global_ctrl_tb.sv
// Self-checking testbench for the global switch control bank.
// Assumes sgc_pkg is compiled first and the storm period is shortened by parameter.
`timescale 1ns/1ps
module testbench;
  import sgc_pkg::*;
  localparam int P100 = 50;
  localparam int P10  = 100;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        strap_dup = 1'b1, strap_fc = 1'b0, strap_spd = 1'b1;
  logic        vlan_o, igmp_o, mld_o, mldopt_o, rep_o, half_o, fc_o, m10_o;
  logic [3:0]  queue_busy_in = 4'h0, grant_out;
  logic        sched_req_in = 1'b0, grant_valid_out;
  logic        sniff_check_in = 1'b0, src_m = 1'b0, dst_m = 1'b0, mirror_out;
  logic        igmp_pkt_in = 1'b0, to_host_out;
  logic        vid_check_in = 1'b0, vid_tagged_in = 1'b0;
  logic [11:0] vid_in = 12'h000, port_vid_in = 12'h000, vid_out;
  logic        link_10m_in = 1'b0, pkt_valid_in = 1'b0, bc_in = 1'b0, grp_in = 1'b0;
  logic [1:0]  pkt_port_in = 2'h0;
  logic [4:0]  pkt_blocks_in = 5'h00;
  logic        drop_out, period_start_out;
  int          failures = 0;
  int          num_checks = 0;

  always #5 mclk_in = ~mclk_in;

  sgc_global_ctrl #(.PERIOD_100M_CYC(P100), .PERIOD_10M_CYC(P10)) dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .host_rx_data_strap_duplex_in(strap_dup),
    .host_rx_data_strap_flowctl_in(strap_fc), .host_rx_data_strap_speed_in(strap_spd),
    .vlan_enable_out(vlan_o), .igmp_snoop_out(igmp_o), .mld_snoop_out(mld_o),
    .mld_option_out(mldopt_o), .repeater_out(rep_o), .host_half_duplex_out(half_o),
    .host_flowctl_out(fc_o), .host_10m_out(m10_o), .queue_busy_in(queue_busy_in),
    .sched_req_in(sched_req_in), .grant_out(grant_out), .grant_valid_out(grant_valid_out),
    .sniff_check_in(sniff_check_in), .sniff_src_match_in(src_m), .sniff_dst_match_in(dst_m),
    .mirror_out(mirror_out), .igmp_pkt_in(igmp_pkt_in), .to_host_out(to_host_out),
    .vid_check_in(vid_check_in), .vid_tagged_in(vid_tagged_in), .vid_in(vid_in),
    .port_vid_in(port_vid_in), .vid_out(vid_out), .link_10m_in(link_10m_in),
    .pkt_valid_in(pkt_valid_in), .pkt_port_in(pkt_port_in), .pkt_da_bcast_in(bc_in),
    .pkt_da_group_in(grp_in), .pkt_blocks_in(pkt_blocks_in), .drop_out(drop_out),
    .period_start_out(period_start_out));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(what, {8'h00, reg_rdata_out}, {8'h00, exp});
  endtask

  task automatic sched(input logic [3:0] busy, output logic [3:0] g);
    @(posedge mclk_in);
    sched_req_in  <= 1'b1;
    queue_busy_in <= busy;
    @(posedge mclk_in);
    sched_req_in <= 1'b0;
    #1;
    check("grant_valid", {15'h0, grant_valid_out}, {15'h0, busy != 4'h0});
    g = grant_out;
  endtask

  // Waits until the cycle right after a period reload, so packets avoid the reload edge
  task automatic wait_period(output int n);
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (period_start_out !== 1'b1 && n < 300);
  endtask

  task automatic pkt(input logic [1:0] p, input logic b, input logic g, input logic [4:0] blk,
                     input logic exp_drop);
    @(posedge mclk_in);
    pkt_valid_in  <= 1'b1;
    pkt_port_in   <= p;
    bc_in         <= b;
    grp_in        <= g;
    pkt_blocks_in <= blk;
    @(posedge mclk_in);
    pkt_valid_in <= 1'b0;
    #1;
    check("drop", {15'h0, drop_out}, {15'h0, exp_drop});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_values();
    check("feature outs", {12'h0, vlan_o, igmp_o, mld_o, mldopt_o}, 16'h0000);
    check("host outs", {12'h0, rep_o, half_o, fc_o, m10_o}, 16'h0005);
    reg_read(ADDR_FEATURE, 8'h00, "feature reset");
    reg_read(ADDR_HOST, 8'h50, "host reset");
    reg_read(ADDR_RATE_LO, 8'h63, "rate low reset");
    reg_read(ADDR_TEST_A, 8'h00, "test a reset");
    reg_read(ADDR_TEST_B, 8'h24, "test b reset");
    reg_read(8'h0A, 8'h00, "unmapped read");
    @(posedge mclk_in);
    #1;
    check("rdata idle", {8'h0, reg_rdata_out}, 16'h0000);
    $display("test reset_values done");
  endtask

  task automatic test_scheduler();
    logic [3:0] g;
    int cnt[4];
    reg_write(ADDR_FEATURE, 8'h00);
    sched(4'h6, g);
    check("strict grant", {12'h0, g}, 16'h0004);
    sched(4'h1, g);
    check("strict low", {12'h0, g}, 16'h0001);
    sched(4'h0, g);
    reg_write(ADDR_FEATURE, 8'h08);
    cnt = '{0, 0, 0, 0};
    for (int i = 0; i < 15; i++) begin
      sched(4'hF, g);
      for (int q = 0; q < 4; q++) if (g[q]) cnt[q]++;
    end
    check("wfq share", 16'(cnt[3] * 4096 + cnt[2] * 256 + cnt[1] * 16 + cnt[0]), 16'h8421);
    cnt = '{0, 0, 0, 0};
    for (int i = 0; i < 12; i++) begin
      sched(4'hB, g);
      for (int q = 0; q < 4; q++) if (g[q]) cnt[q]++;
    end
    check("wfq bonus", 16'(cnt[3] * 4096 + cnt[2] * 256 + cnt[1] * 16 + cnt[0]), 16'h9021);
    $display("test scheduler done");
  endtask

  task automatic test_features();
    for (int m = 0; m < 2; m++) begin
      reg_write(ADDR_FEATURE, m ? 8'hF1 : 8'h00);
      check("feature outs", {12'h0, vlan_o, igmp_o, mld_o, mldopt_o}, m ? 16'hF : 16'h0);
      reg_read(ADDR_FEATURE, m ? 8'hF1 : 8'h00, "feature readback");
      for (int i = 0; i < 4; i++) begin
        @(posedge mclk_in);
        sniff_check_in <= 1'b1;
        igmp_pkt_in    <= 1'b1;
        src_m          <= i[0];
        dst_m          <= i[1];
        @(posedge mclk_in);
        sniff_check_in <= 1'b0;
        igmp_pkt_in    <= 1'b0;
        #1;
        check("mirror", {15'h0, mirror_out}, {15'h0, m ? i[0] & i[1] : i[0] | i[1]});
        check("to_host", {15'h0, to_host_out}, {15'h0, m[0]});
      end
    end
    $display("test features done");
  endtask

  task automatic test_host_vid();
    logic [15:0] cases[3] = '{16'h8000, 16'h8005, 16'h0000};
    reg_write(ADDR_HOST, 8'hA8);
    check("host outs", {12'h0, rep_o, half_o, fc_o, m10_o}, 16'h000A);
    reg_read(ADDR_HOST, 8'hA8, "host readback");
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      vid_check_in  <= 1'b1;
      vid_tagged_in <= cases[i][15];
      vid_in        <= cases[i][11:0];
      port_vid_in   <= 12'hABC;
      @(posedge mclk_in);
      vid_check_in <= 1'b0;
      #1;
      check("vid", {4'h0, vid_out}, (i == 0) ? 16'h0ABC : {4'h0, cases[i][11:0]});
    end
    $display("test host_vid done");
  endtask

  task automatic test_storm();
    int n;
    int d100;
    reg_write(ADDR_HOST, 8'h00);
    reg_write(ADDR_RATE_LO, 8'h03);
    wait_period(n);
    pkt(2'd0, 1'b1, 1'b0, 5'd3, 1'b0);
    pkt(2'd0, 1'b1, 1'b0, 5'd1, 1'b1);
    pkt(2'd0, 1'b0, 1'b1, 5'd1, 1'b0);
    pkt(2'd2, 1'b1, 1'b0, 5'd1, 1'b0);
    reg_write(ADDR_STORM_OPT, 8'h00);
    pkt(2'd0, 1'b0, 1'b1, 5'd1, 1'b1);
    wait_period(n);
    pkt(2'd0, 1'b1, 1'b0, 5'd1, 1'b0);
    wait_period(n);
    wait_period(d100);
    @(posedge mclk_in);
    link_10m_in <= 1'b1;
    wait_period(n);
    wait_period(n);
    check("period 100M", 16'(d100), 16'(P100));
    check("period 10M", 16'(n), 16'(P10));
    $display("test storm done");
  endtask

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
    test_reset_values();
    test_scheduler();
    test_features();
    test_host_vid();
    test_storm();
    complete_run();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    complete_run();
  end
endmodule
